/* dsm_monitor.sv */
/*
 * Drive output signal monitor: overcurrent and zero-current flags,
 * remote output bits with retention, energy pulse output, and the
 * per-terminal function and polarity mapping.
 * Assumes all inputs come from logic on core_clk; rst is the power-on
 * reset, drive_reset a one-cycle drive reset pulse.
 */
//
// Contract
// - While running, flag overcurrent after current exceeds level longer than delay.
// - Overcurrent flag stays on at least the hold time.
// - Hold value 9999 keeps overcurrent flag until next start.
// - Trip select one trips with fault when flag rises; zero continues.
// - After trip flag holds for hold time, or until reset with 9999.
// - Trip select set while flag on takes effect after flag drops.
// - Overcurrent flag goes to terminals coded 12 or inverted 112.
// - While running, flag zero current after current below level long enough.
// - Zero-current flag stays on at least about 0.1 s.
// - Zero-current flag goes to terminals coded 13 or inverted 113.
// - Zero-current level zero disables zero-current detection.
// - Remote bit one turns its terminal on, zero off, inverted if negative.
// - Remote data holds 0 to 4095, one bit per terminal, link writable.
// - Remote function uses code 96 or inverted 196.
// - Retention 0 or 10: power-on reset clears remote data.
// - Retention 1 or 11: save at power-off, restore at recovery only.
// - Retention 10 or 11 keeps remote data over drive reset.
// - Terminals without remote function ignore remote bits.
// - One energy pulse per crossed multiple of increment after reset.
// - Energy count survives retry and short power dips.
// - Power failure clearing control power restarts energy from zero.
// - Energy pulse goes to terminals coded 79 or inverted 179.
`timescale 1ns/1ps
module dsm_monitor #(
    parameter int TICK_CYCLES = dsm_pkg::TICK_CYCLES
) (
    input wire logic core_clk,                      // System clock, 100 MHz
    input wire logic rst,                           // Power-on reset, sync, active high
    input wire logic drive_reset,                   // Drive reset pulse
    input wire logic running,                       // Drive is running
    input wire logic start_cmd,                     // Start command pulse
    input wire logic [7:0] output_current,          // Output current, percent of rated
    input wire logic energy_valid,                  // Energy sample strobe
    input wire logic [15:0] energy_delta,           // Energy since last sample, 0.1 Wh
    input wire logic [7:0] overcurrent_level,       // Overcurrent level, percent
    input wire logic [15:0] overcurrent_delay,      // Overcurrent delay, 10 ms units
    input wire logic [15:0] overcurrent_hold_time,  // Hold, 10 ms units, 9999 latches
    input wire logic overcurrent_trip_select,       // One trips on overcurrent
    input wire logic [7:0] zero_current_level,      // Zero-current level, percent
    input wire logic [15:0] zero_current_time,      // Zero-current time, 10 ms units
    input wire logic [7:0] remote_retention_select, // Remote retention select
    input wire logic [15:0] energy_increment_setting, // Increment, 0.1 kWh units
    input wire logic rem_wr_en,                     // Link write of remote data
    input wire logic [11:0] rem_wr_data,            // Remote data written by link
    input wire logic power_off_warn,                // Control power is going away
    input wire logic nv_restore_valid,              // Saved remote data presented
    input wire logic [11:0] nv_restore_data,        // Saved remote data
    input wire logic [7:0] first_terminal_function_code,  // First terminal function
    input wire logic [7:0] second_terminal_function_code, // Second terminal function
    input wire logic [1:0] term_other_func,         // Other functions per terminal
    output logic [1:0] term_out_q,                  // Terminal outputs, 1 = on
    output logic overcurrent_detect_flag_q,         // Overcurrent flag
    output logic zero_current_flag_q,               // Zero-current flag
    output logic energy_pulse_out_q,                // Energy pulse
    output logic current_trip_fault_q,              // Overcurrent trip fault
    output logic [11:0] remote_output_data_bits_q,  // Remote output data
    output logic nv_save_q,                         // Save strobe to storage
    output logic [11:0] nv_save_data_q              // Data to save
);
    localparam int TW = $clog2(TICK_CYCLES);

    if (TICK_CYCLES < 2)
    begin : g_bad_tick
        $error("dsm_monitor: TICK_CYCLES must be at least 2");
    end

    // Decode function code of one terminal into its driven level
    function automatic logic term_level(input logic [7:0] code, input logic oc,
                                        input logic zc, input logic ep,
                                        input logic remote_output_function, input logic other);
        logic lvl;
        lvl = other;
        unique case (code)
            dsm_pkg::FN_OC_POS: lvl = oc;
            dsm_pkg::FN_OC_NEG: lvl = !oc;
            dsm_pkg::FN_ZC_POS: lvl = zc;
            dsm_pkg::FN_ZC_NEG: lvl = !zc;
            dsm_pkg::FN_EP_POS: lvl = ep;
            dsm_pkg::FN_EP_NEG: lvl = !ep;
            dsm_pkg::FN_REM_POS: lvl = remote_output_function;
            dsm_pkg::FN_REM_NEG: lvl = !remote_output_function;
            default: lvl = other;
        endcase
        return lvl;
    endfunction : term_level

    // Time base
    logic [TW-1:0] tick_cnt_q;
    logic tick_q;
    wire logic tick_wrap = (tick_cnt_q == TW'(TICK_CYCLES - 1));

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
            tick_q <= tick_wrap;
        end
    end

    // Overcurrent detection
    logic oc_exp;
    wire logic oc_cond = running && (output_current > overcurrent_level);

    dsm_qual_timer #(.CW(16)) u_oc_timer (
        .core_clk(core_clk),
        .rst(rst),
        .cond(oc_cond),
        .tick(tick_q),
        .limit(overcurrent_delay),
        .expired_q(oc_exp)
    );

    dsm_pkg::dsm_oc_state_e oc_state_q;
    logic [15:0] oc_hold_cnt_q;
    logic trip_arm_q;
    wire logic hold_latch = (overcurrent_hold_time == dsm_pkg::HOLD_UNTIL_START);
    wire logic hold_done = (oc_hold_cnt_q >= overcurrent_hold_time);
    wire logic oc_rise = (oc_state_q == dsm_pkg::DSM_OC_IDLE) && oc_exp;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            oc_state_q <= dsm_pkg::DSM_OC_IDLE;
            oc_hold_cnt_q <= '0;
        end
        else if (drive_reset)
        begin
            oc_state_q <= dsm_pkg::DSM_OC_IDLE;
            oc_hold_cnt_q <= '0;
        end
        else
        begin
            unique case (oc_state_q)
                dsm_pkg::DSM_OC_IDLE:
                begin
                    oc_hold_cnt_q <= '0;
                    if (oc_exp)
                        oc_state_q <= hold_latch ? dsm_pkg::DSM_OC_LATCH : dsm_pkg::DSM_OC_HOLD;
                end
                dsm_pkg::DSM_OC_HOLD:
                begin
                    if (tick_q && !hold_done)
                        oc_hold_cnt_q <= oc_hold_cnt_q + 1'b1;
                    if (hold_done && !oc_exp)
                        oc_state_q <= dsm_pkg::DSM_OC_IDLE;
                end
                dsm_pkg::DSM_OC_LATCH:
                begin
                    if (start_cmd && !current_trip_fault_q)
                        oc_state_q <= dsm_pkg::DSM_OC_IDLE;
                end
                default: oc_state_q <= dsm_pkg::DSM_OC_IDLE;
            endcase
        end
    end

    // Trip selection and fault
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            trip_arm_q <= 1'b0;
            current_trip_fault_q <= 1'b0;
        end
        else
        begin
            // selection sampled only while flag off
            if (oc_state_q == dsm_pkg::DSM_OC_IDLE)
                trip_arm_q <= overcurrent_trip_select;
            // trip on flag rise, set wins over reset
            if (oc_rise && trip_arm_q)
                current_trip_fault_q <= 1'b1;
            else if (drive_reset)
                current_trip_fault_q <= 1'b0;
        end
    end

    // Zero-current detection
    logic zc_exp;
    logic [7:0] zc_hold_cnt_q;
    wire logic zc_cond = running && (zero_current_level != 8'h00)
                         && (output_current < zero_current_level);
    wire logic zc_min_done = (zc_hold_cnt_q >= 8'(dsm_pkg::ZC_MIN_HOLD_TICKS));

    dsm_qual_timer #(.CW(16)) u_zc_timer (
        .core_clk(core_clk),
        .rst(rst),
        .cond(zc_cond),
        .tick(tick_q),
        .limit(zero_current_time),
        .expired_q(zc_exp)
    );

    always_ff @(posedge core_clk)
    begin
        if (rst || drive_reset)
        begin
            zero_current_flag_q <= 1'b0;
            zc_hold_cnt_q <= '0;
        end
        else if (!zero_current_flag_q)
        begin
            zero_current_flag_q <= zc_exp;
            zc_hold_cnt_q <= '0;
        end
        else
        begin
            if (tick_q && !zc_min_done)
                zc_hold_cnt_q <= zc_hold_cnt_q + 1'b1;
            if (zc_min_done && !zc_exp)
                zero_current_flag_q <= 1'b0;
        end
    end

    // Remote output data with retention
    wire logic ret_keep_pwr = (remote_retention_select == dsm_pkg::RET_KEEP_CLR)
                              || (remote_retention_select == dsm_pkg::RET_KEEP_HOLD);
    wire logic ret_hold_drv = (remote_retention_select == dsm_pkg::RET_CLR_HOLD)
                              || (remote_retention_select == dsm_pkg::RET_KEEP_HOLD);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            remote_output_data_bits_q <= dsm_pkg::REM_DATA_RESET;
            nv_save_q <= 1'b0;
            nv_save_data_q <= dsm_pkg::REM_DATA_RESET;
        end
        else
        begin
            if (rem_wr_en)
                remote_output_data_bits_q <= rem_wr_data;
            else if (nv_restore_valid && ret_keep_pwr)
                remote_output_data_bits_q <= nv_restore_data;
            else if (drive_reset && !ret_hold_drv)
                remote_output_data_bits_q <= dsm_pkg::REM_DATA_RESET;
            nv_save_q <= power_off_warn && ret_keep_pwr;
            if (power_off_warn && ret_keep_pwr)
                nv_save_data_q <= remote_output_data_bits_q;
        end
    end

    // Energy accumulation and pulse
    logic [31:0] energy_acc_q;
    logic ep_pend_q;
    logic [7:0] ep_cnt_q;
    wire logic [31:0] energy_thresh = 32'(energy_increment_setting * dsm_pkg::ENERGY_SCALE);
    wire logic [31:0] energy_sum = energy_acc_q + {16'h0000, energy_delta};
    wire logic energy_cross = energy_valid && (energy_thresh != 32'h0000_0000)
                              && (energy_sum >= energy_thresh);
    wire logic ep_last = tick_q && (ep_cnt_q == 8'(dsm_pkg::EP_WIDTH_TICKS - 1));

    always_ff @(posedge core_clk)
    begin
        // only resets clear, not retry or restart
        if (rst || drive_reset)
            energy_acc_q <= 32'h0000_0000;
        else if (energy_cross)
            energy_acc_q <= energy_sum - energy_thresh;
        else if (energy_valid)
            energy_acc_q <= energy_sum;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || drive_reset)
        begin
            ep_pend_q <= 1'b0;
            ep_cnt_q <= '0;
            energy_pulse_out_q <= 1'b0;
        end
        else
        begin
            if (energy_cross)
                ep_pend_q <= 1'b1;
            else if (!energy_pulse_out_q)
                ep_pend_q <= 1'b0;
            if (!energy_pulse_out_q)
            begin
                energy_pulse_out_q <= ep_pend_q;
                ep_cnt_q <= '0;
            end
            else if (ep_last)
                energy_pulse_out_q <= 1'b0;
            else if (tick_q)
                ep_cnt_q <= ep_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            overcurrent_detect_flag_q <= 1'b0;
        else
            overcurrent_detect_flag_q <= (oc_state_q != dsm_pkg::DSM_OC_IDLE) || oc_rise;
    end

    // Terminal mapping
    wire logic [7:0] term_code [2];
    assign term_code[0] = first_terminal_function_code;
    assign term_code[1] = second_terminal_function_code;

    for (genvar gi = 0; gi < dsm_pkg::NUM_TERM; gi++)
    begin : g_term
        // zero current on 13 or 113
        // energy pulse on 79 or 179
        wire logic lvl = term_level(term_code[gi], overcurrent_detect_flag_q,
                                    zero_current_flag_q, energy_pulse_out_q,
                                    remote_output_data_bits_q[gi], term_other_func[gi]);
        always_ff @(posedge core_clk)
        begin
            if (rst)
                term_out_q[gi] <= 1'b0;
            else
                term_out_q[gi] <= lvl;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_oc_needs_cause: assert property (
        $rose(overcurrent_detect_flag_q) |-> $past(oc_exp) && $past(running, 2))
        else $error("overcurrent flag rose without qualified current");
    chk_oc_hold_min: assert property (
        $fell(overcurrent_detect_flag_q) && !$past(drive_reset, 2)
        |-> $past(hold_done, 2) || $past(start_cmd, 2))
        else $error("overcurrent flag dropped before hold time");
    chk_oc_latch_start: assert property (
        (oc_state_q == dsm_pkg::DSM_OC_LATCH) && !start_cmd && !drive_reset
        |=> oc_state_q == dsm_pkg::DSM_OC_LATCH)
        else $error("latched overcurrent flag left without start");
    chk_trip_on_rise: assert property (
        oc_rise && trip_arm_q |=> current_trip_fault_q)
        else $error("trip fault missing on overcurrent rise");
    chk_fault_keeps_latch: assert property (
        (oc_state_q == dsm_pkg::DSM_OC_LATCH) && current_trip_fault_q && !drive_reset
        |=> oc_state_q == dsm_pkg::DSM_OC_LATCH)
        else $error("tripped latch released without reset");
    chk_no_late_trip: assert property (
        (oc_state_q != dsm_pkg::DSM_OC_IDLE) && !current_trip_fault_q && !oc_rise
        |=> !current_trip_fault_q)
        else $error("trip raised while flag already on");
    chk_zc_disabled: assert property (
        (zero_current_level == 8'h00) [*3] |-> !zc_exp)
        else $error("zero-current detection while disabled");
    chk_zc_min_on: assert property (
        $fell(zero_current_flag_q) && !$past(drive_reset) |-> $past(zc_min_done))
        else $error("zero-current flag dropped too early");
    chk_rem_hold_reset: assert property (
        drive_reset && ret_hold_drv && !rem_wr_en && !nv_restore_valid
        |=> $stable(remote_output_data_bits_q))
        else $error("remote data lost on held drive reset");
    chk_ep_width: assert property (
        $fell(energy_pulse_out_q) && !$past(drive_reset) |-> $past(ep_last))
        else $error("energy pulse ended early");

    cov_oc_trip: cover property (oc_rise && trip_arm_q);
    cov_zc_on: cover property ($rose(zero_current_flag_q));
    cov_ep_pulse: cover property ($rose(energy_pulse_out_q));
    cov_rem_restore: cover property (nv_restore_valid && ret_keep_pwr);
endmodule : dsm_monitor

/* dsm_monitor_tb.sv */
/* Testbench of the drive output monitor: settings, link writes and
   current profiles with expected levels. Assumes a 4-cycle time base. */
`timescale 1ns/1ps
module dsm_monitor_tb;
    logic core_clk = 1'b0, rst = 1'b1, drive_reset = 1'b0, running = 1'b0;
    logic start_cmd = 1'b0, energy_valid = 1'b0, rem_wr_en = 1'b0;
    logic overcurrent_trip_select = 1'b0, power_off_warn = 1'b0, nv_restore_valid = 1'b0;
    logic [7:0] output_current = 8'h00, overcurrent_level = 8'h64, zero_current_level = 8'h00;
    logic [7:0] remote_retention_select = 8'h00, first_terminal_function_code = 8'h00;
    logic [7:0] second_terminal_function_code = 8'h00;
    logic [15:0] energy_delta = 16'h0000, overcurrent_delay = 16'h0002;
    logic [15:0] overcurrent_hold_time = 16'h0002, zero_current_time = 16'h0001;
    logic [15:0] energy_increment_setting = 16'h0001;
    logic [11:0] rem_wr_data = 12'h000, nv_restore_data = 12'h000;
    logic [11:0] remote_output_data_bits_q, nv_save_data_q;
    logic [1:0] term_other_func = 2'b00, term_out_q;
    logic overcurrent_detect_flag_q, zero_current_flag_q, energy_pulse_out_q;
    logic current_trip_fault_q, nv_save_q;
    logic [7:0] on_cnt0, on_cnt1;
    logic [7:0] ep_base;
    int fails = 0;
    int n_compared = 0;
    int i;
    always #5 core_clk = ~core_clk;
    dsm_monitor #(.TICK_CYCLES(4)) u_dut (.*);
    dsm_term_model u_load (.core_clk(core_clk), .rst(rst), .term_out_q(term_out_q),
        .on_cnt0(on_cnt0), .on_cnt1(on_cnt1));
    task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task wr(input logic [11:0] d);
        rem_wr_data = d;
        rem_wr_en = 1'b1;
        cyc(1);
        rem_wr_en = 1'b0;
        cyc(2);
    endtask : wr
    task dreset;
        drive_reset = 1'b1;
        cyc(1);
        drive_reset = 1'b0;
        cyc(2);
    endtask : dreset
    task codes(input logic [7:0] a, input logic [7:0] b);
        first_terminal_function_code = a;
        second_terminal_function_code = b;
        cyc(2);
    endtask : codes
    task energy(input logic [15:0] d);
        energy_delta = d;
        energy_valid = 1'b1;
        cyc(1);
        energy_valid = 1'b0;
        cyc(1);
    endtask : energy
    task restore(input logic [11:0] d);
        nv_restore_data = d;
        nv_restore_valid = 1'b1;
        cyc(1);
        nv_restore_valid = 1'b0;
        cyc(2);
    endtask : restore
    task stop_test;
        $display("Counts: %0d compared, %0d failed", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        #100000;
        fails++;
        stop_test();
    end
    initial
    begin
        cyc(4);
        rst = 1'b0;
        cyc(1);
        chk("rem_data", 12'h000, remote_output_data_bits_q);
        codes(dsm_pkg::FN_REM_POS, dsm_pkg::FN_REM_NEG);
        wr(12'h001);
        chk("term_out", 12'h003, {10'h000, term_out_q});
        wr(12'hFFE);
        chk("rem_data", 12'hFFE, remote_output_data_bits_q);
        chk("term_out", 12'h000, {10'h000, term_out_q});
        remote_retention_select = dsm_pkg::RET_CLR_HOLD;
        dreset();
        chk("rem_data", 12'hFFE, remote_output_data_bits_q);
        remote_retention_select = dsm_pkg::RET_KEEP_CLR;
        power_off_warn = 1'b1;
        cyc(1);
        power_off_warn = 1'b0;
        chk("nv_save", 12'h001, {11'h000, nv_save_q});
        chk("nv_data", 12'hFFE, nv_save_data_q);
        dreset();
        chk("rem_data", 12'h000, remote_output_data_bits_q);
        restore(12'h5A5);
        chk("rem_data", 12'h5A5, remote_output_data_bits_q);
        remote_retention_select = dsm_pkg::RET_CLR_CLR;
        restore(12'h123);
        chk("rem_data", 12'h5A5, remote_output_data_bits_q);
        codes(8'h00, dsm_pkg::FN_REM_POS);
        chk("term_out", 12'h000, {10'h000, term_out_q});
        term_other_func = 2'b01;
        cyc(2);
        chk("term_out", 12'h001, {10'h000, term_out_q});
        $display("test remote done");
        codes(dsm_pkg::FN_OC_POS, dsm_pkg::FN_OC_NEG);
        overcurrent_trip_select = 1'b1;
        running = 1'b1;
        output_current = 8'h96;
        for (i = 0; i < 100 && overcurrent_detect_flag_q !== 1'b1; i++) cyc(1);
        chk("oc_flag", 12'h001, {11'h000, overcurrent_detect_flag_q});
        chk("trip", 12'h001, {11'h000, current_trip_fault_q});
        output_current = 8'h32;
        cyc(2);
        chk("oc_flag", 12'h001, {11'h000, overcurrent_detect_flag_q});
        chk("term_out", 12'h001, {10'h000, term_out_q});
        cyc(20);
        chk("oc_flag", 12'h000, {11'h000, overcurrent_detect_flag_q});
        chk("zc_flag", 12'h000, {11'h000, zero_current_flag_q});
        dreset();
        chk("trip", 12'h000, {11'h000, current_trip_fault_q});
        overcurrent_trip_select = 1'b0;
        overcurrent_hold_time = dsm_pkg::HOLD_UNTIL_START;
        output_current = 8'h96;
        for (i = 0; i < 100 && overcurrent_detect_flag_q !== 1'b1; i++) cyc(1);
        output_current = 8'h00;
        overcurrent_trip_select = 1'b1;
        cyc(60);
        chk("oc_flag", 12'h001, {11'h000, overcurrent_detect_flag_q});
        chk("trip", 12'h000, {11'h000, current_trip_fault_q});
        start_cmd = 1'b1;
        cyc(1);
        start_cmd = 1'b0;
        cyc(3);
        chk("oc_flag", 12'h000, {11'h000, overcurrent_detect_flag_q});
        output_current = 8'h96;
        for (i = 0; i < 100 && overcurrent_detect_flag_q !== 1'b1; i++) cyc(1);
        output_current = 8'h00;
        chk("trip", 12'h001, {11'h000, current_trip_fault_q});
        start_cmd = 1'b1;
        cyc(1);
        start_cmd = 1'b0;
        cyc(3);
        chk("oc_flag", 12'h001, {11'h000, overcurrent_detect_flag_q});
        dreset();
        chk("oc_flag", 12'h000, {11'h000, overcurrent_detect_flag_q});
        overcurrent_trip_select = 1'b0;
        $display("test overcurrent done");
        codes(dsm_pkg::FN_ZC_POS, dsm_pkg::FN_EP_POS);
        chk("zc_flag", 12'h000, {11'h000, zero_current_flag_q});
        zero_current_level = 8'h05;
        for (i = 0; i < 100 && zero_current_flag_q !== 1'b1; i++) cyc(1);
        chk("zc_flag", 12'h001, {11'h000, zero_current_flag_q});
        output_current = 8'h32;
        cyc(12);
        chk("zc_flag", 12'h001, {11'h000, zero_current_flag_q});
        chk("term0", 12'h001, {11'h000, term_out_q[0]});
        ep_base = on_cnt1;
        energy(16'h0258);
        energy(16'h0258);
        cyc(22);
        chk("pulse", 12'h001, {11'h000, energy_pulse_out_q});
        cyc(80);
        chk("ep_count", {4'h0, ep_base + 8'h01}, {4'h0, on_cnt1});
        energy(16'h0258);
        dreset();
        energy(16'h0258);
        cyc(80);
        chk("ep_count", {4'h0, ep_base + 8'h01}, {4'h0, on_cnt1});
        $display("test energy done");
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        cyc(1);
        chk("rem_data", 12'h000, remote_output_data_bits_q);
        energy(16'h0258);
        cyc(5);
        chk("ep_count", 12'h000, {4'h0, on_cnt1});
        $display("test reset done");
        stop_test();
    end
endmodule : dsm_monitor_tb

/* dsm_pkg.sv */
/*
 * Shared constants for the drive output signal monitor: output function
 * codes, setting encodings, time base and reset values.
 * Assumes a 100 MHz core clock; settings arrive as plain ports.
 */
package dsm_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 10_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    // Zero-current flag minimum on time, 0.1 s
    localparam int ZC_MIN_HOLD_MS = 100;
    localparam int ZC_MIN_HOLD_TICKS = (ZC_MIN_HOLD_MS * 1_000_000) / TICK_NS;
    // Energy pulse width seen by external counters, 100 ms
    localparam int EP_WIDTH_MS = 100;
    localparam int EP_WIDTH_TICKS = (EP_WIDTH_MS * 1_000_000) / TICK_NS;
    // Hold time value meaning hold until next start
    localparam logic [15:0] HOLD_UNTIL_START = 16'h270F;
    // Energy input is 0.1 Wh units, increment setting is 0.1 kWh units
    localparam logic [31:0] ENERGY_SCALE = 32'h0000_03E8;
    localparam logic [15:0] ENERGY_INC_RESET = 16'h000A;
    // Terminal function codes
    localparam logic [7:0] FN_OC_POS = 8'h0C;
    localparam logic [7:0] FN_OC_NEG = 8'h70;
    localparam logic [7:0] FN_ZC_POS = 8'h0D;
    localparam logic [7:0] FN_ZC_NEG = 8'h71;
    localparam logic [7:0] FN_EP_POS = 8'h4F;
    localparam logic [7:0] FN_EP_NEG = 8'hB3;
    localparam logic [7:0] FN_REM_POS = 8'h60;
    localparam logic [7:0] FN_REM_NEG = 8'hC4;
    localparam logic [7:0] FN_NEG_BASE = 8'h64;
    // Retention select encodings
    localparam logic [7:0] RET_CLR_CLR = 8'h00;
    localparam logic [7:0] RET_KEEP_CLR = 8'h01;
    localparam logic [7:0] RET_CLR_HOLD = 8'h0A;
    localparam logic [7:0] RET_KEEP_HOLD = 8'h0B;
    // Reset values, terminal count and remote data width
    localparam logic [11:0] REM_DATA_RESET = 12'h000;
    localparam logic [7:0] RET_SEL_RESET = 8'h00;
    localparam int NUM_TERM = 2;
    localparam int REM_BITS = 12;
    // Overcurrent flag states, gray along idle -> hold -> latch
    typedef enum logic [1:0] {
        DSM_OC_IDLE = 2'b00,
        DSM_OC_HOLD = 2'b01,
        DSM_OC_LATCH = 2'b11
    } dsm_oc_state_e;
endpackage : dsm_pkg

/* dsm_qual_timer.sv */
/*
 * Qualification timer: reports expiry once a condition has held for
 * a programmed number of time-base ticks.
 * Assumes cond and tick come from logic on the same clock.
 */
`timescale 1ns/1ps
module dsm_qual_timer #(
    parameter int CW = 16
) (
    input wire logic core_clk,          // System clock
    input wire logic rst,               // Synchronous reset, active high
    input wire logic cond,              // Qualifying condition level
    input wire logic tick,              // Time-base tick pulse
    input wire logic [CW-1:0] limit,    // Ticks the condition must last
    output logic expired_q              // Condition held long enough
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire logic reached = (cnt_q >= limit);

    if (CW < 2)
    begin : g_bad_width
        $error("dsm_qual_timer: CW must be at least 2");
    end

    assign cnt_d = !cond ? '0 : ((tick && !reached) ? cnt_q + 1'b1 : cnt_q);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            expired_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            expired_q <= cond && reached;
        end
    end
endmodule : dsm_qual_timer

/* dsm_term_model.sv */
/* Load model of the output terminals: counts turn-on edges per terminal.
   Assumes terminal levels are registered on core_clk. */
`timescale 1ns/1ps
module dsm_term_model (
    input wire logic core_clk, // System clock
    input wire logic rst, // Power-on reset
    input wire logic [1:0] term_out_q, // Terminal levels, 1 = on
    output logic [7:0] on_cnt0, // Turn-ons of terminal 0
    output logic [7:0] on_cnt1 // Turn-ons of terminal 1
);
    logic [1:0] prev_q;
    always_ff @(posedge core_clk)
    begin
        prev_q <= rst ? 2'b00 : term_out_q;
        if (rst)
        begin
            on_cnt0 <= 8'h00;
            on_cnt1 <= 8'h00;
        end
        else
        begin
            on_cnt0 <= on_cnt0 + 8'(term_out_q[0] & ~prev_q[0]);
            on_cnt1 <= on_cnt1 + 8'(term_out_q[1] & ~prev_q[1]);
        end
    end
endmodule : dsm_term_model
